/* File: pin_select_pkg.sv */
/*
 Package for the pin function select block: pin counts, port bases, register offsets,
 reset defaults and the packed structs that carry per-pin configuration and routing.
 Assumes a single 40 MHz clock domain and a plain strobe register port.
*/
package pin_select_pkg;
	// Ports A..G, eight bit slots each (unused bits held at zero)
	localparam int num_ports = 7;
	localparam int pins_per_port = 8;
	localparam int num_pins = 56;
	localparam int code_width = 4;
	localparam int addr_width = 8;
	// Pin index of each port's bit 0
	localparam int port_a = 0;
	localparam int port_b = 8;
	localparam int port_c = 16;
	localparam int port_d = 24;
	localparam int port_e = 32;
	localparam int port_f = 40;
	localparam int port_g = 48;
	// Register block per port: offset = port * port_stride + register offset
	localparam logic [7:0] port_stride = 8'h20;
	localparam logic [4:0] alternate_select_reg = 5'h00;
	localparam logic [4:0] digital_enable_reg = 5'h04;
	localparam logic [4:0] analog_mode_reg = 5'h08;
	localparam logic [4:0] pull_up_reg = 5'h0c;
	localparam logic [4:0] pull_down_reg = 5'h10;
	localparam logic [4:0] port_control_reg = 5'h14;
	localparam logic [4:0] direction_reg = 5'h18;
	localparam logic [4:0] data_reg = 5'h1c;
	// Function codes and defaults
	localparam logic [3:0] code_none = 4'h0;
	localparam logic [3:0] code_periph = 4'h1;
	localparam logic [3:0] code_debug = 4'h3;
	localparam logic [31:0] unmapped_read = 32'h0000_0000;

	typedef struct packed {
		logic alt_sel;
		logic dig_en;
		logic ana_sel;
		logic pull_up;
		logic pull_down;
		logic dir;
		logic dout;
		logic [3:0] code;
	} pin_cfg_type;

	typedef struct packed {
		logic oe;
		logic out;
		logic periph_en;
		logic [3:0] periph_code;
		logic adc_connect;
		logic comp_connect;
		logic pull_up;
		logic pull_down;
	} pin_route_type;

	// Which pins feed the converter through isolation, which are comparator pins
	localparam logic [55:0] adc_pins = 56'h00_0000_0000_0000;
	localparam logic [55:0] comp_pins = 56'h00_0000_0020_7000;
	// Reset-default masks per field
	localparam logic [55:0] rst_alt = 56'h00_0000_000f_0c3f;
	localparam logic [55:0] rst_pull_up = 56'h00_0000_000f_0000;
	localparam logic [55:0] rst_debug = 56'h00_0000_000f_0000;
endpackage : pin_select_pkg

/* File: pin_route.sv */
/*
 One pin's routing decision from its configuration word.
 Assumes the configuration arrives registered; the result is pure combinational.
*/
`timescale 1ns/10ps
module pin_route
	import pin_select_pkg::*;
(
	input wire pin_cfg_type cfg_i,
	input wire logic is_adc_i,
	input wire logic is_comp_i,
	input wire logic periph_oe_i,
	input wire logic periph_out_i,
	output pin_route_type route_o
);
	// Decide the path for this pin alone
	always_comb begin
		route_o.periph_en = cfg_i.alt_sel & cfg_i.dig_en;
		route_o.periph_code = route_o.periph_en ? cfg_i.code : code_none;
		route_o.adc_connect = is_adc_i & ~cfg_i.dig_en & cfg_i.ana_sel;
		route_o.comp_connect = is_comp_i & ~cfg_i.dig_en;
		route_o.pull_up = cfg_i.pull_up;
		route_o.pull_down = cfg_i.pull_down;
		if (route_o.periph_en) begin
			route_o.oe = periph_oe_i;
			route_o.out = periph_out_i;
		end else begin
			route_o.oe = cfg_i.dir & cfg_i.dig_en;
			route_o.out = cfg_i.dout;
		end
	end
endmodule : pin_route

/* File: pin_function_select.sv */
/*
 Per-pin function selection for GPIO ports A..G with register port and reset defaults.
 Assumes one clock, asynchronous active-low reset, peripherals supplying output and enable.
*/
`timescale 1ns/10ps
// Notes on behaviour
// - Peripheral drives pin only with alternate select and digital enable; the pin's own slot drives it, whatever the code.
// - Converter input connects only with digital enable clear and analog select set.
// - Comparator pins connect whenever digital enable is clear.
// - Each pin has its own configuration word; a write touches that field of all eight pins of the addressed port.
// - Default pins reset to tri-stated GPIO with all fields zero.
// - Power-on or external reset restores all pin defaults.
// - Port A 5:0 and port B 3:2 reset to peripheral with code 1.
// - Port C 3:0 reset to debug with pull-up and code 3.
// - Alternate map assigns fixed peripherals per port as documented.
module pin_function_select
	import pin_select_pkg::*;
(
	input wire logic clock_i,
	input wire logic nrst_i,
	input wire logic [7:0] addr_i,
	input wire logic [31:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	input wire logic [55:0] periph_oe_i,
	input wire logic [55:0] periph_out_i,
	output logic [31:0] rdata_o,
	output logic [55:0] pin_oe_o,
	output logic [55:0] pin_out_o,
	output logic [55:0] periph_en_o,
	output logic [55:0] adc_connect_o,
	output logic [55:0] comp_connect_o,
	output logic [55:0] pull_up_o,
	output logic [55:0] pull_down_o
);
	pin_cfg_type cfg [num_pins];
	pin_cfg_type next_cfg [num_pins];
	pin_route_type route [num_pins];
	logic [31:0] next_rdata;
	logic [2:0] port_sel;
	logic [4:0] reg_sel;
	logic port_ok;

	// Reset value of one pin's configuration
	function automatic pin_cfg_type reset_cfg(input int p);
		pin_cfg_type c;
		c = '0;
		c.alt_sel = rst_alt[p];
		c.dig_en = rst_alt[p];
		c.pull_up = rst_pull_up[p];
		c.code = rst_debug[p] ? code_debug : (rst_alt[p] ? code_periph : code_none);
		return c;
	endfunction : reset_cfg

	// Field of a port selected by register offset, one bit per pin in the low byte, four bits per pin for port control
	function automatic logic [31:0] read_field(input int base, input logic [4:0] r);
		logic [31:0] v;
		v = '0;
		for (int b = 0; b < pins_per_port; b++) begin
			unique case (r)
				alternate_select_reg: v[b] = cfg[base + b].alt_sel;
				digital_enable_reg: v[b] = cfg[base + b].dig_en;
				analog_mode_reg: v[b] = cfg[base + b].ana_sel;
				pull_up_reg: v[b] = cfg[base + b].pull_up;
				pull_down_reg: v[b] = cfg[base + b].pull_down;
				port_control_reg: v[b*4 +: 4] = cfg[base + b].code;
				direction_reg: v[b] = cfg[base + b].dir;
				data_reg: v[b] = cfg[base + b].dout;
				default: v = unmapped_read;
			endcase
		end
		return v;
	endfunction : read_field

	// Address decode
	always_comb begin
		port_sel = 3'(addr_i / port_stride);
		reg_sel = addr_i[4:0];
		port_ok = (int'(port_sel) < num_ports) && (addr_i[1:0] == 2'h0);
	end

	// Next configuration: a write changes only the addressed pins' own bits
	always_comb begin
		for (int p = 0; p < num_pins; p++) begin
			next_cfg[p] = cfg[p];
			if (wr_i && port_ok && (p / pins_per_port == int'(port_sel))) begin
				unique case (reg_sel)
					alternate_select_reg: next_cfg[p].alt_sel = wdata_i[p % 8];
					digital_enable_reg: next_cfg[p].dig_en = wdata_i[p % 8];
					analog_mode_reg: next_cfg[p].ana_sel = wdata_i[p % 8];
					pull_up_reg: next_cfg[p].pull_up = wdata_i[p % 8];
					pull_down_reg: next_cfg[p].pull_down = wdata_i[p % 8];
					port_control_reg: next_cfg[p].code = wdata_i[(p % 8)*4 +: 4];
					direction_reg: next_cfg[p].dir = wdata_i[p % 8];
					data_reg: next_cfg[p].dout = wdata_i[p % 8];
					default: next_cfg[p] = cfg[p];
				endcase
			end
		end
		next_rdata = (rd_i && port_ok) ? read_field(int'(port_sel) * 8, reg_sel) : unmapped_read;
	end

	// Configuration registers, restored on any reset
	always_ff @(posedge clock_i or negedge nrst_i) begin
		if (!nrst_i) begin
			for (int p = 0; p < num_pins; p++) begin
				cfg[p] <= reset_cfg(p);
			end
			rdata_o <= '0;
		end else begin
			for (int p = 0; p < num_pins; p++) begin
				cfg[p] <= next_cfg[p];
			end
			rdata_o <= next_rdata;
		end
	end

	// Per-pin routing; peripheral slots follow the fixed alternate map
	for (genvar g = 0; g < num_pins; g++) begin : gen_pin
		pin_route u_route (
			.cfg_i(cfg[g]),
			.is_adc_i(adc_pins[g]),
			.is_comp_i(comp_pins[g]),
			.periph_oe_i(periph_oe_i[g]),
			.periph_out_i(periph_out_i[g]),
			.route_o(route[g])
		);
	end

	// Registered pin outputs
	always_ff @(posedge clock_i or negedge nrst_i) begin
		if (!nrst_i) begin
			pin_oe_o <= '0;
			pin_out_o <= '0;
			periph_en_o <= '0;
			adc_connect_o <= '0;
			comp_connect_o <= '0;
			pull_up_o <= '0;
			pull_down_o <= '0;
		end else begin
			for (int p = 0; p < num_pins; p++) begin
				pin_oe_o[p] <= route[p].oe;
				pin_out_o[p] <= route[p].out;
				periph_en_o[p] <= route[p].periph_en;
				adc_connect_o[p] <= route[p].adc_connect;
				comp_connect_o[p] <= route[p].comp_connect;
				pull_up_o[p] <= route[p].pull_up;
				pull_down_o[p] <= route[p].pull_down;
			end
		end
	end

	// Per-pin terms as vectors, so the checks below can compare whole outputs at once
	logic [55:0] both_sel;
	logic [55:0] gpio_oe;
	logic [55:0] gpio_out;
	logic [55:0] dig_on;
	logic [55:0] pu_cfg;
	logic [55:0] pd_cfg;
	always_comb begin
		for (int p = 0; p < num_pins; p++) begin
			both_sel[p] = cfg[p].alt_sel & cfg[p].dig_en;
			gpio_oe[p] = cfg[p].dir & cfg[p].dig_en;
			gpio_out[p] = cfg[p].dout;
			dig_on[p] = cfg[p].dig_en;
			pu_cfg[p] = cfg[p].pull_up;
			pd_cfg[p] = cfg[p].pull_down;
		end
	end

	// Routing checks; the first edge after a release still shows the reset zeros
	a_periph_gate: assert property (@(posedge clock_i) disable iff (!nrst_i)
		periph_en_o[port_a] |-> $past(cfg[port_a].alt_sel & cfg[port_a].dig_en))
		else $error("peripheral enabled without select");
	a_periph_all: assert property (@(posedge clock_i) disable iff (!nrst_i)
		$past(nrst_i) |-> periph_en_o == $past(both_sel))
		else $error("peripheral enables do not follow the select bits");
	a_pin_oe_mux: assert property (@(posedge clock_i) disable iff (!nrst_i)
		$past(nrst_i) |-> pin_oe_o == $past((both_sel & periph_oe_i) | (~both_sel & gpio_oe)))
		else $error("pin output enable from the wrong source");
	a_pin_out_mux: assert property (@(posedge clock_i) disable iff (!nrst_i)
		$past(nrst_i) |-> pin_out_o == $past((both_sel & periph_out_i) | (~both_sel & gpio_out)))
		else $error("pin output value from the wrong source");
	a_comp_link: assert property (@(posedge clock_i) disable iff (!nrst_i)
		$past(nrst_i) |-> comp_connect_o[port_b + 4] == $past(~cfg[port_b + 4].dig_en))
		else $error("comparator path wrong");
	a_comp_all: assert property (@(posedge clock_i) disable iff (!nrst_i)
		$past(nrst_i) |-> comp_connect_o == $past(comp_pins & ~dig_on))
		else $error("comparator paths do not follow digital enable");
	a_adc_off: assert property (@(posedge clock_i) disable iff (!nrst_i)
		adc_connect_o == '0)
		else $error("converter path on a non-converter pin");
	a_pull_follow: assert property (@(posedge clock_i) disable iff (!nrst_i)
		$past(nrst_i) |-> pull_up_o == $past(pu_cfg) && pull_down_o == $past(pd_cfg))
		else $error("pull enables do not follow their bits");
	a_gpio_drive: assert property (@(posedge clock_i) disable iff (!nrst_i)
		!$past(route[port_d + 2].periph_en)
		|-> pin_out_o[port_d + 2] == $past(cfg[port_d + 2].dout))
		else $error("gpio data not driven");

	// Reset defaults, looked at on the first edge after a release
	a_debug_reset: assert property (@(posedge clock_i)
		$rose(nrst_i) |-> cfg[port_c].code == code_debug && cfg[port_c].pull_up)
		else $error("debug pin reset wrong");
	a_uart_reset: assert property (@(posedge clock_i)
		$rose(nrst_i) |-> cfg[port_a].code == code_periph && cfg[port_a].dig_en)
		else $error("port a reset wrong");
	a_plain_reset: assert property (@(posedge clock_i)
		$rose(nrst_i) |-> cfg[port_d] == '0)
		else $error("plain pin reset wrong");

	// A port A control write must leave the code of port B bit 2 alone
	a_neighbour_kept: assert property (@(posedge clock_i) disable iff (!nrst_i)
		wr_i && addr_i == 8'(port_control_reg)
		|=> cfg[port_b + 2].code == $past(cfg[port_b + 2].code))
		else $error("write reached another port");

	// Main scenarios
	c_periph_on: cover property (@(posedge clock_i) disable iff (!nrst_i) $rose(periph_en_o[port_d + 2]));
	c_comp_off: cover property (@(posedge clock_i) disable iff (!nrst_i) $fell(comp_connect_o[port_b + 4]));
	c_read: cover property (@(posedge clock_i) disable iff (!nrst_i) rd_i ##1 rdata_o != '0);
	c_gpio_drive: cover property (@(posedge clock_i) disable iff (!nrst_i) $rose(pin_oe_o[port_d + 2]));
	c_debug_code: cover property (@(posedge clock_i) disable iff (!nrst_i) route[port_c].periph_code == code_debug);
endmodule : pin_function_select

/* File: periph_model.sv */
/*
 Peripheral side model: drives a fixed per-pin enable pattern and a value pattern.
 Assumes the bench clock and reset; flip_i inverts the value pattern from the next edge.
*/
`timescale 1ns/10ps
module periph_model (
	input wire logic clock_i,
	input wire logic nrst_i,
	input wire logic flip_i,
	output logic [55:0] oe_o,
	output logic [55:0] out_o
);
	// Value pattern changes only just after an edge, like a real peripheral register
	always_ff @(posedge clock_i or negedge nrst_i) begin
		if (!nrst_i) begin
			out_o <= 56'h00_0000_0000_0000;
		end else begin
			out_o <= {7{8'h0f}} ^ {56{flip_i}};
		end
	end
	// Alternating enables, so a wrong pin mapping shows up
	assign oe_o = 56'h55_aa55_aa55_aa55;
endmodule : periph_model

/* File: pin_function_select_bench.sv */
/*
 Bench for the pin function select block: a table of register accesses with refusal cases, then routing,
 comparator and reset cases. Assumes the peripheral model and a 40 MHz clock.
*/
`timescale 1ns/10ps
module pin_function_select_bench
	import pin_select_pkg::*;
;
	typedef struct {logic [7:0] a; logic w; logic [31:0] d; logic [31:0] e;} row_type;
	logic clock_i = 1'h0;
	logic nrst_i = 1'h0;
	logic [7:0] addr_i = 8'h00;
	logic [31:0] wdata_i = 32'h0;
	logic wr_i = 1'h0;
	logic rd_i = 1'h0;
	logic flip = 1'h0;
	logic [55:0] oe_pat, out_pat, pin_oe, pin_out, en, adc, comp, pu, pd;
	logic [31:0] rdata, r;
	int mismatches = 0;
	int n_checks = 0;
	// Register address, write flag, write data, expected read
	row_type rows [9] = '{'{8'h14, 1'h0, 32'h0, 32'h0011_1111}, '{8'h34, 1'h0, 32'h0, 32'h0000_1100},
		'{8'h54, 1'h0, 32'h0, 32'h0000_3333}, '{8'h4c, 1'h0, 32'h0, 32'h0000_000f},
		'{8'h24, 1'h0, 32'h0, 32'h0000_000c}, '{8'h90, 1'h0, 32'h0, 32'h0},
		'{8'h14, 1'h1, 32'h0f11_1111, 32'h0f11_1111}, '{8'he4, 1'h1, 32'hff, 32'h0},
		'{8'h15, 1'h0, 32'h0, 32'h0}};

	always #12.5 clock_i = ~clock_i;

	periph_model partner (.clock_i(clock_i), .nrst_i(nrst_i), .flip_i(flip), .oe_o(oe_pat),
		.out_o(out_pat));
	pin_function_select dut (.clock_i(clock_i), .nrst_i(nrst_i), .addr_i(addr_i),
		.wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .periph_oe_i(oe_pat),
		.periph_out_i(out_pat), .rdata_o(rdata), .pin_oe_o(pin_oe), .pin_out_o(pin_out),
		.periph_en_o(en), .adc_connect_o(adc), .comp_connect_o(comp), .pull_up_o(pu),
		.pull_down_o(pd));

	task automatic close_out;
		if (mismatches == 0 && n_checks > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : close_out

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clock_i);
		addr_i <= a;
		wdata_i <= d;
		wr_i <= 1'h1;
		@(posedge clock_i);
		wr_i <= 1'h0;
	endtask : wr

	// Read data stand only in the cycle after the strobe
	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge clock_i);
		addr_i <= a;
		rd_i <= 1'h1;
		@(posedge clock_i);
		rd_i <= 1'h0;
		@(negedge clock_i);
		d = rdata;
	endtask : rd

	task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("wrong value at %0t: read %h expected %h", $time, got, exp);
		end
	endtask : chk_reg

	task automatic chk_pins(input logic [55:0] got, input logic [55:0] exp);
		n_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("wrong value at %0t: pins %h expected %h", $time, got, exp);
		end
	endtask : chk_pins

	// Outputs follow the configuration one edge late; wait three
	task automatic settle;
		repeat (3) @(posedge clock_i);
		@(negedge clock_i);
	endtask : settle

	task automatic chk_route(input logic [55:0] e, input logic [55:0] goe, input logic [55:0] gout);
		settle;
		chk_pins(en, e);
		chk_pins(pin_oe, (e & oe_pat) | goe);
		chk_pins(pin_out, (e & out_pat) | gout);
	endtask : chk_route

	task automatic chk_defaults;
		chk_route(rst_alt, '0, '0);
		chk_pins(pu, rst_pull_up);
		chk_pins(pd | adc, '0);
		chk_pins(comp, comp_pins);
	endtask : chk_defaults

	// Main sequence
	initial begin
		repeat (8) @(posedge clock_i);
		nrst_i <= 1'h1;
		chk_defaults;
		foreach (rows[i]) begin
			if (rows[i].w) wr(rows[i].a, rows[i].d);
			rd(rows[i].a, r);
			chk_reg(r, rows[i].e);
		end
		// Port D bit 2 as driven GPIO, then handed to its peripheral
		wr(8'h64, 32'h04);
		wr(8'h78, 32'h04);
		wr(8'h7c, 32'h04);
		chk_route(rst_alt, 56'h1 << 26, 56'h1 << 26);
		wr(8'h60, 32'h04);
		flip <= 1'h1;
		chk_route(rst_alt | (56'h1 << 26), '0, '0);
		// Comparator pin loses its direct path once digital enable is set
		wr(8'h24, 32'h1c);
		wr(8'h28, 32'h20);
		wr(8'h30, 32'h80);
		settle;
		chk_pins(comp, comp_pins & ~(56'h1 << 12));
		chk_pins(adc, '0);
		chk_pins(en, rst_alt | (56'h1 << 26));
		chk_pins(pd, 56'h1 << 15);
		// Reset in mid-run
		@(posedge clock_i);
		nrst_i <= 1'h0;
		flip <= 1'h0;
		repeat (2) @(posedge clock_i);
		nrst_i <= 1'h1;
		chk_defaults;
		rd(8'h64, r);
		chk_reg(r, 32'h0);
		close_out;
	end

	// Watchdog: the sequence needs about 65 cycles
	initial begin
		repeat (2000) @(posedge clock_i);
		mismatches++;
		close_out;
	end
endmodule : pin_function_select_bench
